// ### crx_exec.v
// Purpose: Execute stage for moves, returns, rotates, subtracts, swap, xor,
//          legacy loads, no-operation and power-down
// Assumes: Fetch path offers one instruction word at a time on the same clock
// Notes:   Tags mark the logic of each rule
// Overview of operation
// RULE_01: Destination bit chooses accumulator or file register
// RULE_02: Literal return loads accumulator, pops, two cycles
// RULE_03: Subroutine return pops into counter, two cycles
// RULE_04: Rotate right through carry, only carry changes
// RULE_05: Rotate left through carry, only carry changes
// RULE_06: Power-down clears pd, sets to, clears watchdog
// RULE_07: After power-down, halt oscillator in low power
// RULE_08: Literal minus accumulator, updates carry, digit, zero
// RULE_09: File minus accumulator, routed, updates three flags
// RULE_10: Subtract carry is set when no borrow
// RULE_11: Xor literal into accumulator, zero flag only
// RULE_12: Xor file with accumulator, routed, zero only
// RULE_13: Legacy direction load writes direction register 5-7
// RULE_14: Moves take one cycle, only file move touches zero
// RULE_15: Nibble swap routed, no flag changes
// RULE_16: Interrupt return pops and sets global enable
`timescale 1ns/10ps
`default_nettype none
`include "crx_regs.vh"
module crx_exec
#(
    parameter AW = 13
)
(
    input  wire          I_SYS_CLK,
    input  wire          I_RST,
    input  wire          I_WB_CYC,
    input  wire          I_WB_STB,
    input  wire          I_WB_WE,
    input  wire [7:0]    I_WB_ADR,
    input  wire [3:0]    I_WB_SEL,
    input  wire [31:0]   I_WB_DAT,
    output reg  [31:0]   O_WB_DAT,
    output reg           O_WB_ACK,
    input  wire [13:0]   I_INSTR,
    input  wire          I_INSTR_VALID,
    output wire          O_INSTR_READY,
    input  wire          I_PUSH,
    input  wire [AW-1:0] I_PUSH_ADDR,
    input  wire          I_WAKE,
    output reg  [6:0]    O_FILE_ADDR,
    input  wire [7:0]    I_FILE_RDATA,
    output reg           O_FILE_WE,
    output reg  [7:0]    O_FILE_WDATA,
    output reg           O_PC_LOAD,
    output reg  [AW-1:0] O_PC_VALUE,
    output reg           O_WATCHDOG_CLEAR,
    output reg           O_SLEEP,
    output reg           O_GLOBAL_INT_EN,
    output reg  [7:0]    O_OPTION,
    output reg  [7:0]    O_DIRECTION_5,
    output reg  [7:0]    O_DIRECTION_6,
    output reg  [7:0]    O_DIRECTION_7
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_EXEC   = 2'h1;
    localparam ST_SECOND = 2'h2;
    localparam ST_SLEEP  = 2'h3;

    reg  [1:0]    state_reg;
    reg  [1:0]    state_next;
    reg  [13:0]   instr_reg;
    reg  [7:0]    accum_reg;
    reg           carry_reg;
    reg           digit_reg;
    reg           zero_reg;
    reg           pdown_reg;
    reg           tout_reg;
    reg           unsup_reg;
    reg           ack_reg;
    reg           wake_s1_reg;
    reg           wake_s2_reg;

    reg  [2:0]    alu_sel;
    reg  [7:0]    alu_opnd;
    reg           to_file;
    reg           to_accum;
    reg           upd_c;
    reg           upd_dc;
    reg           upd_z;
    reg           do_pop;
    reg           do_gie;
    reg           do_sleep;
    reg           do_option;
    reg           do_dir;
    reg           is_unsup;
    wire [7:0]    alu_res;
    wire          alu_c;
    wire          alu_dc;
    wire [AW-1:0] stack_top;

    wire exec    = (state_reg == ST_EXEC);
    wire wb_req  = I_WB_CYC & I_WB_STB & ~ack_reg;
    wire wb_wr   = wb_req & I_WB_WE;
    wire wr_acc  = wb_wr & I_WB_SEL[0] & (I_WB_ADR == `CRX_ADR_ACCUM);
    wire wr_st   = wb_wr & (I_WB_ADR == `CRX_ADR_STATUS);
    wire two_cyc = exec & do_pop;

    assign O_INSTR_READY = (state_reg == ST_IDLE);

    function is_two_cycle;
        input [13:0] op;
        begin
            is_two_cycle = (op == `CRX_OP_RETURN) || (op == `CRX_OP_INTRET) ||
                           (op[13:10] == `CRX_OP_RETLW4);
        end
    endfunction

    crx_alu u_alu
    (
        .i_sel    (alu_sel),
        .i_opnd   (alu_opnd),
        .i_accum  (accum_reg),
        .i_carry  (carry_reg),
        .o_result (alu_res),
        .o_carry  (alu_c),
        .o_digit  (alu_dc)
    );

    crx_stack #(.DEPTH(8), .PTRW(3), .AW(AW)) u_stack
    (
        .i_sys_clk   (I_SYS_CLK),
        .i_rst       (I_RST),
        .i_push      (I_PUSH),
        .i_push_addr (I_PUSH_ADDR),
        .i_pop       (exec & do_pop),
        .o_top       (stack_top)
    );

    // Instruction decode
    always @*
    begin
        alu_sel   = `CRX_ALU_PASS;
        alu_opnd  = I_FILE_RDATA;
        to_file   = 1'b0;
        to_accum  = 1'b0;
        upd_c     = 1'b0;
        upd_dc    = 1'b0;
        upd_z     = 1'b0;
        do_pop    = 1'b0;
        do_gie    = 1'b0;
        do_sleep  = 1'b0;
        do_option = 1'b0;
        do_dir    = 1'b0;
        is_unsup  = 1'b0;
        if (instr_reg[13:12] == 2'b00)
        begin
            to_file  = instr_reg[7];                            // [RULE_01]
            to_accum = ~instr_reg[7];                           // [RULE_01]
            case (instr_reg[13:8])
                `CRX_OP_MOVE_F: upd_z = 1'b1;                   // [RULE_14]
                `CRX_OP_ROT_R:
                begin
                    alu_sel = `CRX_ALU_ROT_R;                   // [RULE_04]
                    upd_c   = 1'b1;
                end
                `CRX_OP_ROT_L:
                begin
                    alu_sel = `CRX_ALU_ROT_L;                   // [RULE_05]
                    upd_c   = 1'b1;
                end
                `CRX_OP_SUB_F:
                begin
                    alu_sel = `CRX_ALU_SUB;                     // [RULE_09]
                    upd_c   = 1'b1;
                    upd_dc  = 1'b1;
                    upd_z   = 1'b1;
                end
                `CRX_OP_XOR_F:
                begin
                    alu_sel = `CRX_ALU_XOR;                     // [RULE_12]
                    upd_z   = 1'b1;
                end
                `CRX_OP_SWAP_F: alu_sel = `CRX_ALU_SWAP;        // [RULE_15]
                default:
                begin
                    to_file  = 1'b0;
                    to_accum = 1'b0;
                    alu_opnd = accum_reg;
                    if (instr_reg[13:7] == `CRX_OP_STORE7)
                        to_file = 1'b1;                         // [RULE_14]
                    else if (instr_reg == `CRX_OP_RETURN)
                        do_pop = 1'b1;                          // [RULE_03]
                    else if (instr_reg == `CRX_OP_INTRET)
                    begin
                        do_pop = 1'b1;                          // [RULE_16]
                        do_gie = 1'b1;
                    end
                    else if (instr_reg == `CRX_OP_SLEEP)
                        do_sleep = 1'b1;                        // [RULE_06]
                    else if (instr_reg == `CRX_OP_OPTION)
                        do_option = 1'b1;
                    else if (instr_reg[13:3] == `CRX_OP_DIRLOAD11 &&
                             instr_reg[2:0] >= 3'h5)
                        do_dir = 1'b1;                          // [RULE_13]
                    else if (instr_reg[13:7] != 7'h00 || instr_reg[4:0] != 5'h00)
                        is_unsup = 1'b1;
                end
            endcase
        end
        else if (instr_reg[13:12] == 2'b11)
        begin
            alu_opnd = instr_reg[7:0];
            if (instr_reg[13:10] == `CRX_OP_LOAD_L4)
                to_accum = 1'b1;                                // [RULE_14]
            else if (instr_reg[13:10] == `CRX_OP_RETLW4)
            begin
                to_accum = 1'b1;                                // [RULE_02]
                do_pop   = 1'b1;
            end
            else if (instr_reg[13:9] == `CRX_OP_SUB_L5)
            begin
                alu_sel  = `CRX_ALU_SUB;                        // [RULE_08]
                to_accum = 1'b1;
                upd_c    = 1'b1;
                upd_dc   = 1'b1;
                upd_z    = 1'b1;
            end
            else if (instr_reg[13:8] == `CRX_OP_XOR_L6)
            begin
                alu_sel  = `CRX_ALU_XOR;                        // [RULE_11]
                to_accum = 1'b1;
                upd_z    = 1'b1;
            end
            else
                is_unsup = 1'b1;
        end
        else
            is_unsup = 1'b1;
    end

    // Sequencer
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (I_INSTR_VALID)
                    state_next = ST_EXEC;
            ST_EXEC:
                if (two_cyc)
                    state_next = ST_SECOND;                     // [RULE_02] [RULE_03]
                else if (do_sleep)
                    state_next = ST_SLEEP;                      // [RULE_07]
                else
                    state_next = ST_IDLE;
            ST_SECOND: state_next = ST_IDLE;
            ST_SLEEP:
                if (wake_s2_reg)
                    state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            state_reg        <= ST_IDLE;
            instr_reg        <= 14'h0000;
            accum_reg        <= `CRX_RST_ACCUM;
            {tout_reg, pdown_reg, zero_reg, digit_reg, carry_reg} <= `CRX_RST_FLAGS;
            unsup_reg        <= 1'b0;
            ack_reg          <= 1'b0;
            wake_s1_reg      <= 1'b0;
            wake_s2_reg      <= 1'b0;
            O_WB_DAT         <= 32'h00000000;
            O_WB_ACK         <= 1'b0;
            O_FILE_ADDR      <= 7'h00;
            O_FILE_WE        <= 1'b0;
            O_FILE_WDATA     <= 8'h00;
            O_PC_LOAD        <= 1'b0;
            O_PC_VALUE       <= {AW{1'b0}};
            O_WATCHDOG_CLEAR <= 1'b0;
            O_SLEEP          <= 1'b0;
            O_GLOBAL_INT_EN  <= 1'b0;
            O_OPTION         <= `CRX_RST_OPTION;
            O_DIRECTION_5    <= `CRX_RST_DIRECTION;
            O_DIRECTION_6    <= `CRX_RST_DIRECTION;
            O_DIRECTION_7    <= `CRX_RST_DIRECTION;
        end
        else
        begin
            state_reg        <= state_next;
            wake_s1_reg      <= I_WAKE;
            wake_s2_reg      <= wake_s1_reg;
            O_FILE_WE        <= 1'b0;
            O_PC_LOAD        <= 1'b0;
            O_WATCHDOG_CLEAR <= 1'b0;
            O_SLEEP          <= (state_next == ST_SLEEP);       // [RULE_07]
            if (O_INSTR_READY && I_INSTR_VALID)
            begin
                instr_reg   <= I_INSTR;
                O_FILE_ADDR <= I_INSTR[6:0];
            end
            // Execution results override bus writes
            if (wr_acc)
                accum_reg <= I_WB_DAT[7:0];
            if (wr_st && I_WB_SEL[0])
            begin
                carry_reg       <= I_WB_DAT[`CRX_ST_CARRY];
                digit_reg       <= I_WB_DAT[`CRX_ST_DIGIT];
                zero_reg        <= I_WB_DAT[`CRX_ST_ZERO];
                pdown_reg       <= I_WB_DAT[`CRX_ST_PDOWN];
                tout_reg        <= I_WB_DAT[`CRX_ST_TOUT];
                O_GLOBAL_INT_EN <= I_WB_DAT[`CRX_ST_GIE];
            end
            if (wr_st && I_WB_SEL[1] && I_WB_DAT[`CRX_ST_UNSUP])
                unsup_reg <= 1'b0;
            if (exec)
            begin
                if (to_accum)
                    accum_reg <= alu_res;                       // [RULE_01]
                if (to_file)
                begin
                    O_FILE_WE    <= 1'b1;                       // [RULE_01]
                    O_FILE_WDATA <= alu_res;
                end
                if (upd_c)
                    carry_reg <= alu_c;                         // [RULE_10]
                if (upd_dc)
                    digit_reg <= alu_dc;
                if (upd_z)
                    zero_reg <= (alu_res == 8'h00);
                if (do_pop)
                begin
                    O_PC_LOAD  <= 1'b1;                         // [RULE_03]
                    O_PC_VALUE <= stack_top;
                end
                if (do_gie)
                    O_GLOBAL_INT_EN <= 1'b1;                    // [RULE_16]
                if (do_sleep)
                begin
                    pdown_reg        <= 1'b0;                   // [RULE_06]
                    tout_reg         <= 1'b1;
                    O_WATCHDOG_CLEAR <= 1'b1;
                end
                if (do_option)
                    O_OPTION <= accum_reg;
                if (do_dir)
                    case (instr_reg[1:0])
                        2'h1:    O_DIRECTION_5 <= accum_reg;    // [RULE_13]
                        2'h2:    O_DIRECTION_6 <= accum_reg;
                        default: O_DIRECTION_7 <= accum_reg;
                    endcase
                if (is_unsup)
                    unsup_reg <= 1'b1;
            end
            // Bus slave answer, one wait state
            ack_reg  <= wb_req;
            O_WB_ACK <= wb_req;
            O_WB_DAT <= 32'h00000000;
            if (wb_req && !I_WB_WE)
                case (I_WB_ADR)
                    `CRX_ADR_ACCUM:     O_WB_DAT <= {24'h000000, accum_reg};
                    `CRX_ADR_STATUS:    O_WB_DAT <= {23'h000000, unsup_reg,
                                            ~O_INSTR_READY, O_SLEEP,
                                            O_GLOBAL_INT_EN, tout_reg,
                                            pdown_reg, zero_reg,
                                            digit_reg, carry_reg};
                    `CRX_ADR_PC:        O_WB_DAT <= {{(32-AW){1'b0}}, O_PC_VALUE};
                    `CRX_ADR_OPTION:    O_WB_DAT <= {24'h000000, O_OPTION};
                    `CRX_ADR_DIRECTION: O_WB_DAT <= {8'h00, O_DIRECTION_7,
                                            O_DIRECTION_6, O_DIRECTION_5};
                    default:            O_WB_DAT <= 32'h00000000;
                endcase
        end
    end
endmodule // crx_exec
`default_nettype wire

// ### crx_regs.vh
// Purpose: Shared constants of the instruction execute block
// Assumes: Included by bare name from the execute stage and the operation unit
// Notes:   Offsets are byte addresses on the register bus
`ifndef CRX_REGS_VH
`define CRX_REGS_VH

// Register bus offsets
`define CRX_ADR_ACCUM       8'h00
`define CRX_ADR_STATUS      8'h04
`define CRX_ADR_PC          8'h08
`define CRX_ADR_OPTION      8'h0C
`define CRX_ADR_DIRECTION   8'h10

// Status register field positions
`define CRX_ST_CARRY        0
`define CRX_ST_DIGIT        1
`define CRX_ST_ZERO         2
`define CRX_ST_PDOWN        3
`define CRX_ST_TOUT         4
`define CRX_ST_GIE          5
`define CRX_ST_SLEEP        6
`define CRX_ST_BUSY         7
`define CRX_ST_UNSUP        8

// Reset values
`define CRX_RST_ACCUM       8'h00
`define CRX_RST_OPTION      8'hFF
`define CRX_RST_DIRECTION   8'hFF
`define CRX_RST_FLAGS       5'h18

// Timing counts in instruction cycles
`define CRX_CYC_BRANCH      2
`define CRX_CYC_SIMPLE      1

// Opcode patterns
`define CRX_OP_STORE7       7'h01
`define CRX_OP_RETURN       14'h0008
`define CRX_OP_INTRET       14'h0009
`define CRX_OP_OPTION       14'h0062
`define CRX_OP_SLEEP        14'h0063
`define CRX_OP_DIRLOAD11    11'h00C
`define CRX_OP_MOVE_F       6'h08
`define CRX_OP_ROT_R        6'h0C
`define CRX_OP_ROT_L        6'h0D
`define CRX_OP_SUB_F        6'h02
`define CRX_OP_XOR_F        6'h06
`define CRX_OP_SWAP_F       6'h0E
`define CRX_OP_LOAD_L4      4'hC
`define CRX_OP_RETLW4       4'hD
`define CRX_OP_SUB_L5       5'h1E
`define CRX_OP_XOR_L6       6'h3A

// Operation unit selects
`define CRX_ALU_PASS        3'h0
`define CRX_ALU_ROT_R       3'h1
`define CRX_ALU_ROT_L       3'h2
`define CRX_ALU_SUB         3'h3
`define CRX_ALU_XOR         3'h4
`define CRX_ALU_SWAP        3'h5

`endif

// ### crx_alu.v
// Purpose: Combinational operation unit
// Assumes: Select codes from crx_regs.vh
// Notes:   Subtract gives operand minus accumulator; carry is the inverted borrow
`timescale 1ns/10ps
`default_nettype none
`include "crx_regs.vh"
module crx_alu
(
    input  wire [2:0] i_sel,
    input  wire [7:0] i_opnd,
    input  wire [7:0] i_accum,
    input  wire       i_carry,
    output reg  [7:0] o_result,
    output reg        o_carry,
    output reg        o_digit
);
    reg [8:0] diff;
    reg [4:0] ndiff;

    always @*
    begin
        diff     = {1'b0, i_opnd} + {1'b0, ~i_accum} + 9'h001;
        ndiff    = {1'b0, i_opnd[3:0]} + {1'b0, ~i_accum[3:0]} + 5'h01;
        o_result = i_opnd;
        o_carry  = i_carry;
        o_digit  = 1'b0;
        case (i_sel)
            `CRX_ALU_ROT_R:
            begin
                o_result = {i_carry, i_opnd[7:1]};
                o_carry  = i_opnd[0];
            end
            `CRX_ALU_ROT_L:
            begin
                o_result = {i_opnd[6:0], i_carry};
                o_carry  = i_opnd[7];
            end
            `CRX_ALU_SUB:
            begin
                o_result = diff[7:0];
                o_carry  = diff[8];
                o_digit  = ndiff[4];
            end
            `CRX_ALU_XOR:  o_result = i_opnd ^ i_accum;
            `CRX_ALU_SWAP: o_result = {i_opnd[3:0], i_opnd[7:4]};
            default:       o_result = i_opnd;
        endcase
    end
endmodule // crx_alu
`default_nettype wire

// ### crx_stack.v
// Purpose: Return address stack held in flip-flops
// Assumes: Push and pop never in the same cycle
// Notes:   Wraps silently on overflow and underflow
`timescale 1ns/10ps
`default_nettype none
module crx_stack
#(
    parameter DEPTH = 8,
    parameter PTRW  = 3,
    parameter AW    = 13
)
(
    input  wire          i_sys_clk,
    input  wire          i_rst,
    input  wire          i_push,
    input  wire [AW-1:0] i_push_addr,
    input  wire          i_pop,
    output wire [AW-1:0] o_top
);
    reg [AW-1:0]   mem_reg [0:DEPTH-1];
    reg [PTRW-1:0] ptr_reg;
    integer        k;

    assign o_top = mem_reg[ptr_reg - {{(PTRW-1){1'b0}}, 1'b1}];

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ptr_reg <= {PTRW{1'b0}};
            for (k = 0; k < DEPTH; k = k + 1)
                mem_reg[k] <= {AW{1'b0}};
        end
        else if (i_push)
        begin
            mem_reg[ptr_reg] <= i_push_addr;
            ptr_reg          <= ptr_reg + {{(PTRW-1){1'b0}}, 1'b1};
        end
        else if (i_pop)
            ptr_reg <= ptr_reg - {{(PTRW-1){1'b0}}, 1'b1};
    end
endmodule // crx_stack
`default_nettype wire

// ### crx_exec_asserts.sv
// Purpose: Port-level assertions for the execute stage
// Assumes: One clock; reset asynchronous and active high
// Notes:   Results show two edges after accept
`timescale 1ns/10ps
`default_nettype none
module crx_exec_chk
(
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    input wire logic        I_WB_CYC,
    input wire logic        I_WB_STB,
    input wire logic        O_WB_ACK,
    input wire logic [13:0] I_INSTR,
    input wire logic        I_INSTR_VALID,
    input wire logic        O_INSTR_READY,
    input wire logic [7:0]  I_FILE_RDATA,
    input wire logic [6:0]  O_FILE_ADDR,
    input wire logic        O_FILE_WE,
    input wire logic [7:0]  O_FILE_WDATA,
    input wire logic        O_PC_LOAD,
    input wire logic        O_WATCHDOG_CLEAR,
    input wire logic        O_SLEEP,
    input wire logic        O_GLOBAL_INT_EN
);
    wire acc = O_INSTR_READY && I_INSTR_VALID;
    // File ops with a destination bit
    wire fop = I_INSTR[13:12] == 2'h0 && (I_INSTR[11:8] inside {4'h2, 4'h6, 4'h8, 4'hC, 4'hD, 4'hE});
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    dest_route_a: assert property (acc && fop |-> ##2 (O_FILE_WE == $past(I_INSTR[7], 2)))
        else $error("file write does not follow destination bit");
    file_addr_a: assert property (acc |=> O_FILE_ADDR == $past(I_INSTR[6:0]))
        else $error("file address not taken from instruction");
    lit_ret_a: assert property (acc && I_INSTR[13:10] == 4'hD |-> ##2 O_PC_LOAD)
        else $error("literal return gave no counter load");
    ret_load_a: assert property (acc && I_INSTR == 14'h0008 |-> ##2 O_PC_LOAD)
        else $error("return gave no counter load");
    ret_two_a: assert property (acc && I_INSTR == 14'h0008 |=> !O_INSTR_READY [*2] ##1 O_INSTR_READY)
        else $error("return did not take two cycles");
    load_one_a: assert property (acc && I_INSTR[13:10] == 4'hC |=> !O_INSTR_READY ##1 O_INSTR_READY)
        else $error("literal load did not take one cycle");
    swap_data_a: assert property (acc && I_INSTR[13:7] == 7'h1D |-> ##2 O_FILE_WE && O_FILE_WDATA == {$past(I_FILE_RDATA[3:0]), $past(I_FILE_RDATA[7:4])})
        else $error("nibble swap wrote wrong data");
    sleep_entry_a: assert property (acc && I_INSTR == 14'h0063 |-> ##2 O_SLEEP && O_WATCHDOG_CLEAR)
        else $error("power-down did not clear watchdog and halt");
    sleep_hold_a: assert property (O_SLEEP |-> !O_INSTR_READY)
        else $error("instruction taken while halted");
    iret_gie_a: assert property (acc && I_INSTR == 14'h0009 |-> ##2 O_PC_LOAD && O_GLOBAL_INT_EN)
        else $error("interrupt return did not pop and enable");
    bus_ack_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("bus acknowledge not a single pulse");
    c_sleep: cover property (acc && I_INSTR == 14'h0063);
    c_iret: cover property (acc && I_INSTR == 14'h0009);
    c_fwrite: cover property (O_FILE_WE);
endmodule // crx_exec_chk
bind crx_exec crx_exec_chk u_chk (.*);
`default_nettype wire

// ### crx_exec_tb.sv
// Purpose: Self-checking bench for the execute stage
// Assumes: Combinational file read
// Notes:   Monitor pops one queued note per result
`timescale 1ns/10ps
`default_nettype none
module crx_exec_tb;
    logic        clk, rst, cyc, we, vld, push, wake;
    logic [7:0]  adr, rdat;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [13:0] ins;
    logic [12:0] padr;
    wire  [31:0] dat_o;
    wire  [12:0] pcv;
    wire  [7:0]  fwd;
    wire         ack, rdy, fwe, pcl, wdc, slp;
    int          bad_count, checked;
    logic [33:0] q[$];
    logic [13:0] base [10] = '{14'h0800, 14'h0C00, 14'h0D00, 14'h0200, 14'h0600,
                               14'h0E00, 14'h0080, 14'h3000, 14'h3C00, 14'h3A00};

    crx_exec dut (.I_SYS_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(dat_o), .O_WB_ACK(ack),
        .I_INSTR(ins), .I_INSTR_VALID(vld), .O_INSTR_READY(rdy), .I_PUSH(push),
        .I_PUSH_ADDR(padr), .I_WAKE(wake), .O_FILE_ADDR(), .I_FILE_RDATA(rdat),
        .O_FILE_WE(fwe), .O_FILE_WDATA(fwd), .O_PC_LOAD(pcl), .O_PC_VALUE(pcv),
        .O_WATCHDOG_CLEAR(wdc), .O_SLEEP(slp), .O_GLOBAL_INT_EN(), .O_OPTION(),
        .O_DIRECTION_5(), .O_DIRECTION_6(), .O_DIRECTION_7());

    task automatic report_and_stop;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask

    function automatic logic [33:0] nxt();
        if (q.size() == 0)
            return '1;
        return q.pop_front();
    endfunction

    task automatic guard(inout int n);
        n++;
        if (n > 60)
        begin
            bad_count++;
            report_and_stop;
        end
    endtask

    // Classic single cycle; for a read, d is the expected data
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        if (!w)
            q.push_back({2'd2, d});
        cyc <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        do begin @(posedge clk); guard(n); end while (ack !== 1'b1);
        cyc <= 1'b0;
        @(posedge clk);
    endtask

    task automatic ex(input logic [13:0] op, input logic [7:0] fd);
        int n;
        n = 0;
        ins <= op; rdat <= fd; vld <= 1'b1;
        do begin @(posedge clk); guard(n); end while (rdy !== 1'b1);
        vld <= 1'b0;
    endtask

    task automatic idle;
        int n;
        n = 0;
        do begin @(posedge clk); guard(n); end while (rdy !== 1'b1);
    endtask

    task automatic pu(input logic [12:0] a);
        push <= 1'b1; padr <= a;
        @(posedge clk);
        push <= 1'b0;
        @(posedge clk);
    endtask

    // Reference result {zero, digit carry, carry, data}
    function automatic logic [10:0] alu(input int i, input logic [7:0] f, w, input logic [2:0] st);
        logic [7:0] r;
        logic       z, dc, cy;
        {z, dc, cy} = st;
        r = f;
        case (i)
            1: {r, cy} = {cy, f};
            2: {cy, r} = {f, cy};
            3, 8: {cy, r} = {1'b1, f} - {1'b0, w};
            4, 9: r = f ^ w;
            5: r = {f[3:0], f[7:4]};
            6: r = w;
            default: r = f;
        endcase
        if (i == 3 || i == 8)
            dc = f[3:0] >= w[3:0];
        if (i inside {0, 3, 4, 8, 9})
            z = r == 8'h00;
        return {z, dc, cy, r};
    endfunction

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (fwe === 1'b1) chk({2'd0, 24'h0, fwd}, nxt());
        if (pcl === 1'b1) chk({2'd1, 19'h0, pcv}, nxt());
        if (wdc === 1'b1) chk({2'd3, 31'h0, slp}, nxt());
        if (ack === 1'b1 && we === 1'b0) chk({2'd2, dat_o}, nxt());
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end

    initial
    begin
        logic [7:0]  w, f, k;
        logic [6:0]  fa;
        logic [2:0]  st;
        logic        d;
        logic [10:0] e;
        logic [12:0] a1, a2;
        logic [23:0] dv;
        rst = 1'b1; cyc = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; sel = 4'hF;
        ins = 14'h0000; vld = 1'b0; rdat = 8'h00; push = 1'b0; padr = 13'h0000; wake = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(43));
        @(posedge clk);
        wb(0, 8'h00, 32'h0);
        wb(0, 8'h04, 32'h18);
        wb(0, 8'h0C, 32'hFF);
        wb(0, 8'h10, 32'h00FFFFFF);
        wb(1, 8'h14, 32'h5A);
        wb(0, 8'h14, 32'h0);
        for (int i = 0; i < 10; i++)
            for (int n = 0; n < 5; n++)
            begin
                w = 8'($urandom); f = 8'($urandom); fa = 7'($urandom);
                st = 3'($urandom); d = (i == 6) || (i < 6 && 1'($urandom));
                wb(1, 8'h00, {24'h0, w});
                wb(1, 8'h04, {29'h3, st});
                e = alu(i, f, w, st);
                if (d)
                    q.push_back({2'd0, 24'h0, e[7:0]});
                ex((i > 6) ? (base[i] | {6'h0, f}) : (base[i] | {6'h0, d, fa}), (i > 6) ? ~f : f);
                idle;
                wb(0, 8'h00, {24'h0, d ? w : e[7:0]});
                wb(0, 8'h04, {29'h3, e[10:8]});
            end
        wb(1, 8'h04, 32'h18);
        a1 = 13'($urandom); a2 = 13'($urandom); k = 8'($urandom);
        pu(a1);
        pu(a2);
        q.push_back({2'd1, 19'h0, a2});
        ex(14'h0008, 8'h00);
        idle;
        q.push_back({2'd1, 19'h0, a1});
        ex(14'h3400 | {6'h0, k}, 8'h00);
        idle;
        wb(0, 8'h00, {24'h0, k});
        wb(0, 8'h04, 32'h18);
        pu(a1 ^ a2);
        q.push_back({2'd1, 19'h0, a1 ^ a2});
        ex(14'h0009, 8'h00);
        idle;
        wb(0, 8'h04, 32'h38);
        dv = 24'($urandom);
        for (int j = 0; j < 3; j++)
        begin
            wb(1, 8'h00, {24'h0, dv[8*j +: 8]});
            ex(14'h0065 + 14'(j), 8'h00);
            idle;
        end
        wb(0, 8'h10, {8'h0, dv});
        ex(14'h0061, 8'h00);
        idle;
        wb(0, 8'h04, 32'h138);
        wb(1, 8'h04, 32'h100, 4'h2);
        wb(0, 8'h04, 32'h38);
        q.push_back({2'd3, 32'h1});
        ex(14'h0063, 8'h00);
        repeat (4) @(posedge clk);
        wake <= 1'b1;
        idle;
        wake <= 1'b0;
        wb(0, 8'h04, 32'h30);
        repeat (3) @(posedge clk);
        chk(34'(q.size()), 34'h0);
        report_and_stop;
    end
endmodule // crx_exec_tb
`default_nettype wire
